// ==== pcgu_pkg.sv ====
package pcgu_pkg;

    // =========================================================
    // Register window.
    // =========================================================
    localparam logic [31:0] PCGU_BASE_DEFAULT = 32'hfffc_4000;
    localparam logic [31:0] PCGU_TOP3M_FLOOR  = 32'hffd0_0000;
    localparam int          PCGU_WIN_BITS     = 14;
    localparam logic [13:0] PCGU_OFS_SET      = 14'h0000;
    localparam logic [13:0] PCGU_OFS_CLR      = 14'h0004;
    localparam logic [13:0] PCGU_OFS_STAT     = 14'h0008;

    // =========================================================
    // Field positions.
    // =========================================================
    localparam int PCGU_CORE_BIT = 0;
    localparam int PCGU_PER_LSB  = 1;

    // =========================================================
    // Types.
    // =========================================================
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } pcgu_req_t;

    typedef enum logic [1:0] {
        PCGU_RUN      = 2'b00,
        PCGU_STOPPING = 2'b01,
        PCGU_HALTED   = 2'b11
    } pcgu_core_t;

endpackage

// ==== pcgu_clock_gating_manager.sv ====
`timescale 1ns/10ps

// What this block does
// - Separate clock enables for the processor core and each gated peripheral.
// - Core clock stop waits until the current instruction completes.
// - Halted core clock restarts on an enabled pending interrupt or hardware reset.
// - Disabling a peripheral clock stops it at once.
// - Re-enabled peripheral resumes from the state it held when stopped.
// - RAM and gated module registers keep their values while clocks stop.
// - Control register has three locations; ones written at the first set bits.
// - Ones at the second location clear bits; third location reads value.
// - Zero bits written at set or clear locations change nothing.
// - Register space is a 16K byte window in the top 3M bytes.
// - Base is the window's lowest address; offsets count upward from it.
module pcgu_clock_gating_manager #(
    parameter int          N_PERIPH = 16,
    parameter logic [31:0] BASE     = pcgu_pkg::PCGU_BASE_DEFAULT
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire pcgu_pkg::pcgu_req_t  i_req,
    input  wire logic                 i_insn_done,
    input  wire logic                 i_irq_pending,
    output logic [31:0]               o_rdata,
    output logic                      o_core_clk,
    output logic [N_PERIPH-1:0]       o_periph_clk,
    output logic                      o_core_halted
);

    // =========================================================
    // Address decode.
    // =========================================================
    logic                    in_win;
    logic [13:0]             ofs;
    logic                    wr_set;
    logic                    wr_clr;
    logic                    rd_stat;
    logic [N_PERIPH:0]       stat_q;
    logic [N_PERIPH:0]       stat_d;
    logic [N_PERIPH:0]       gate_en_q;
    pcgu_pkg::pcgu_core_t    core_q;
    pcgu_pkg::pcgu_core_t    core_d;
    logic                    wake;

    // The window must sit in the top 3M bytes; a bad base is caught at elaboration.
    if (BASE < pcgu_pkg::PCGU_TOP3M_FLOOR || BASE[pcgu_pkg::PCGU_WIN_BITS-1:0] != '0) begin : g_bad_base
        $error("Base address outside the top 3M bytes or not window aligned.");
    end

    assign in_win  = (i_req.addr[31:pcgu_pkg::PCGU_WIN_BITS] == BASE[31:pcgu_pkg::PCGU_WIN_BITS]);
    assign ofs     = i_req.addr[pcgu_pkg::PCGU_WIN_BITS-1:0];

    // Set and clear writes decode first; a request with both strobes at the read location still returns data.
    always_comb begin
        wr_set  = 1'b0;
        wr_clr  = 1'b0;
        rd_stat = 1'b0;
        if (in_win && i_req.wr && ofs == pcgu_pkg::PCGU_OFS_SET) begin
            wr_set = 1'b1;
        end else if (in_win && i_req.wr && ofs == pcgu_pkg::PCGU_OFS_CLR) begin
            wr_clr = 1'b1;
        end else if (in_win && i_req.rd && ofs == pcgu_pkg::PCGU_OFS_STAT) begin
            rd_stat = 1'b1;
        end
    end

    // =========================================================
    // Enable register.
    // =========================================================
    assign wake = (core_q == pcgu_pkg::PCGU_HALTED) && i_irq_pending;

    always_comb begin
        stat_d = stat_q;
        if (wr_set) begin
            stat_d = stat_q | i_req.wdata[N_PERIPH:0];
        end else if (wr_clr) begin
            stat_d = stat_q & ~i_req.wdata[N_PERIPH:0];
        end
        // A wake-up interrupt wins over a clear landing in the same cycle.
        if (wake) begin
            stat_d[pcgu_pkg::PCGU_CORE_BIT] = 1'b1;
        end
    end

    // Reset enables every clock, which is also the hardware-reset restart path.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stat_q <= '1;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Unmapped reads and reads of the write-only locations return zero.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (rd_stat) begin
            o_rdata <= 32'(stat_q);
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // =========================================================
    // Core clock stop sequence.
    // =========================================================
    // A clear already in the register when the instruction finishes halts at once; a clear
    // written in that same cycle is seen one edge later, so the core waits for the next one.
    always_comb begin
        core_d = core_q;
        case (core_q)
            pcgu_pkg::PCGU_RUN: begin
                if (!stat_q[pcgu_pkg::PCGU_CORE_BIT]) begin
                    core_d = i_insn_done ? pcgu_pkg::PCGU_HALTED : pcgu_pkg::PCGU_STOPPING;
                end
            end
            pcgu_pkg::PCGU_STOPPING: begin
                if (stat_q[pcgu_pkg::PCGU_CORE_BIT]) begin
                    core_d = pcgu_pkg::PCGU_RUN;
                end else if (i_insn_done) begin
                    core_d = pcgu_pkg::PCGU_HALTED;
                end
            end
            pcgu_pkg::PCGU_HALTED: begin
                if (i_irq_pending || stat_q[pcgu_pkg::PCGU_CORE_BIT]) begin
                    core_d = pcgu_pkg::PCGU_RUN;
                end
            end
            default: core_d = pcgu_pkg::PCGU_RUN;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            core_q <= pcgu_pkg::PCGU_RUN;
        end else begin
            core_q <= core_d;
        end
    end

    assign o_core_halted = (core_q == pcgu_pkg::PCGU_HALTED);

    // =========================================================
    // Glitch-free gates.
    // =========================================================
    // Enables are retimed on the falling edge, so an AND gate only ever opens or
    // closes while the clock is low. A stopped module simply sees no edges and its
    // flops and RAM hold, which is why no state needs saving around a stop.
    always_ff @(negedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gate_en_q <= '1;
        end else begin
            gate_en_q <= {stat_q[N_PERIPH:pcgu_pkg::PCGU_PER_LSB], core_q != pcgu_pkg::PCGU_HALTED};
        end
    end

    assign o_core_clk = i_clk & gate_en_q[0];

    for (genvar g = 0; g < N_PERIPH; g++) begin : g_gate
        assign o_periph_clk[g] = i_clk & gate_en_q[g+1];
    end

    // =========================================================
    // Assertions.
    // =========================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // The gate enables are retimed half a cycle after each rising edge, so at the
    // next rising edge they must equal the state and enables sampled there.

    sequence s_drop_core;
        core_q == pcgu_pkg::PCGU_RUN && !stat_q[0] && !i_insn_done;
    endsequence

    sequence s_finish_insn;
        core_q == pcgu_pkg::PCGU_STOPPING && !stat_q[0] && i_insn_done;
    endsequence

    sequence s_core_reenabled;
        core_q == pcgu_pkg::PCGU_STOPPING && stat_q[0];
    endsequence

    a_set_write_ones: assert property (wr_set && !wake |=> stat_q == ($past(stat_q) | $past(i_req.wdata[N_PERIPH:0])))
        else $error("Set location did not set the written ones.");
    a_clr_write_ones: assert property (wr_clr && !wake |=> stat_q == ($past(stat_q) & ~$past(i_req.wdata[N_PERIPH:0])))
        else $error("Clear location did not clear the written ones.");
    a_zero_write_noop: assert property ((wr_set || wr_clr) && i_req.wdata == 32'h0 && !wake |=> $stable(stat_q))
        else $error("Writing zeros changed the enable register.");
    a_stat_read_back: assert property (rd_stat |=> o_rdata == 32'($past(stat_q)))
        else $error("Status read did not return the stored value.");
    a_read_no_change: assert property (rd_stat && !wake |=> $stable(stat_q))
        else $error("A status read changed the enable register.");
    a_rdata_idle_zero: assert property (!rd_stat |=> o_rdata == 32'h0000_0000)
        else $error("Read data did not return to zero.");
    a_outside_window: assert property (!in_win && !wake |=> $stable(stat_q))
        else $error("Access outside the window changed the register.");
    a_bad_offset: assert property (in_win && i_req.wr && !wr_set && !wr_clr && !wake |=> $stable(stat_q))
        else $error("A write to an unused offset changed the register.");

    // =========================================================
    // Stop sequence checks.
    // =========================================================
    a_core_stays_on: assert property (core_q == pcgu_pkg::PCGU_RUN && stat_q[0] |=> core_q == pcgu_pkg::PCGU_RUN)
        else $error("Core left run while its enable was set.");
    a_core_waits_insn: assert property (s_drop_core |=> core_q == pcgu_pkg::PCGU_STOPPING && gate_en_q[0])
        else $error("Core clock stopped before the instruction ended.");
    a_halt_needs_insn: assert property ($rose(o_core_halted) |-> $past(i_insn_done))
        else $error("Core halted without a finished instruction.");
    a_stop_cancelled: assert property (s_core_reenabled |=> core_q == pcgu_pkg::PCGU_RUN)
        else $error("Re-enabled core did not return to run.");
    a_core_then_halts: assert property (s_finish_insn |=> o_core_halted && !gate_en_q[0])
        else $error("Core did not halt after its instruction ended.");
    a_irq_wakes_core: assert property (wake |=> core_q == pcgu_pkg::PCGU_RUN && stat_q[0] ##1 gate_en_q[0])
        else $error("Pending interrupt did not restart the core clock.");
    a_core_gate_track: assert property (gate_en_q[0] == (core_q != pcgu_pkg::PCGU_HALTED))
        else $error("Core gate does not follow the stop state.");
    a_periph_gate_now: assert property (gate_en_q[N_PERIPH:1] == stat_q[N_PERIPH:1])
        else $error("Peripheral gate did not follow its enable at once.");

endmodule // pcgu_clock_gating_manager

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
    // =========================================================
    // Bench signals.
    // =========================================================
    localparam logic [31:0] B   = pcgu_pkg::PCGU_BASE_DEFAULT;
    localparam logic [31:0] ALL = 32'h0001_ffff;
    logic                i_clk;
    logic                i_sys_rst;
    logic                i_insn_done;
    logic                i_irq_pending;
    pcgu_pkg::pcgu_req_t i_req;
    logic [31:0]         o_rdata;
    logic                o_core_clk;
    logic                o_core_halted;
    logic [15:0]         o_periph_clk;
    int                  bad_count  = 0;
    int                  num_checks = 0;
    int                  cyc        = 0;
    int                  core_n     = 0;
    int                  per_n      = 0;
    int                  hi_n       = 0;

    pcgu_clock_gating_manager #(.N_PERIPH(16), .BASE(B)) pcgu_clock_gating_manager_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_insn_done(i_insn_done),
        .i_irq_pending(i_irq_pending), .o_rdata(o_rdata), .o_core_clk(o_core_clk),
        .o_periph_clk(o_periph_clk), .o_core_halted(o_core_halted));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // Edge counters measure how many pulses the core clock and peripheral clocks 0 and 15 let through.
    always @(posedge o_core_clk) core_n++;
    always @(posedge o_periph_clk[0]) per_n++;
    always @(posedge o_periph_clk[15]) hi_n++;

    // The whole run needs well under 150 cycles; this ceiling only catches a hang.
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            summarize();
        end
    end

    // =========================================================
    // Shared tasks.
    // =========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Requests last one cycle; read data is looked at in the cycle after the taking edge.
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(negedge i_clk);
        i_req = '{wr: wr, rd: ~wr, addr: a, wdata: d};
        @(negedge i_clk);
        i_req = '0;
    endtask

    task automatic read_exp(input logic [31:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0000_0000);
        check(o_rdata, exp);
    endtask

    task automatic count_clk(input int n, input int exp_core, input int exp_per, input int exp_hi);
        int c0;
        int p0;
        int h0;
        c0 = core_n;
        p0 = per_n;
        h0 = hi_n;
        repeat (n) @(negedge i_clk);
        check(32'(core_n - c0), 32'(exp_core));
        check(32'(per_n - p0), 32'(exp_per));
        check(32'(hi_n - h0), 32'(exp_hi));
    endtask

    task automatic insn_pulse();
        @(negedge i_clk);
        i_insn_done = 1'b1;
        @(negedge i_clk);
        i_insn_done = 1'b0;
    endtask

    // =========================================================
    // Scenarios.
    // =========================================================
    task automatic t_reset_state();
        read_exp(B + 32'h8, ALL);
        read_exp(B, 32'h0000_0000);
        count_clk(4, 4, 4, 4);
    endtask

    task automatic t_periph();
        access(1'b1, B + 32'h4, 32'h0000_0002);
        read_exp(B + 32'h8, 32'h0001_fffd);
        count_clk(4, 4, 0, 4);
        access(1'b1, B, 32'h0000_0000);
        access(1'b1, B + 32'h4, 32'h0000_0000);
        read_exp(B + 32'h8, 32'h0001_fffd);
        access(1'b1, B, 32'h0000_0002);
        read_exp(B + 32'h8, ALL);
        count_clk(4, 4, 4, 4);
        access(1'b1, B + 32'h4, 32'h0001_0000);
        read_exp(B + 32'h8, 32'h0000_ffff);
        count_clk(4, 4, 4, 0);
        access(1'b1, B, 32'h0001_0000);
        count_clk(4, 4, 4, 4);
    endtask

    task automatic t_window();
        access(1'b1, B - 32'h0000_3ffc, 32'h0000_0002);
        access(1'b1, B + 32'h0000_4004, 32'h0000_0002);
        access(1'b1, B + 32'h0000_000c, 32'h0000_0002);
        read_exp(B + 32'h8, ALL);
        read_exp(B + 32'h0000_4008, 32'h0000_0000);
    endtask

    task automatic t_core();
        access(1'b1, B + 32'h4, 32'h0000_0001);
        read_exp(B + 32'h8, 32'h0001_fffe);
        count_clk(3, 3, 3, 3);
        check(32'(o_core_halted), 32'h0);
        insn_pulse();
        check(32'(o_core_halted), 32'h1);
        count_clk(4, 0, 4, 4);
        @(negedge i_clk);
        i_irq_pending = 1'b1;
        @(negedge i_clk);
        i_irq_pending = 1'b0;
        check(32'(o_core_halted), 32'h0);
        count_clk(4, 4, 4, 4);
        read_exp(B + 32'h8, ALL);
    endtask

    // Re-enabling the core before its instruction ends cancels the stop.
    task automatic t_core_abort();
        access(1'b1, B + 32'h4, 32'h0000_0001);
        access(1'b1, B, 32'h0000_0001);
        insn_pulse();
        check(32'(o_core_halted), 32'h0);
        count_clk(4, 4, 4, 4);
    endtask

    task automatic t_hw_restart();
        access(1'b1, B + 32'h4, 32'h0000_0003);
        insn_pulse();
        check(32'(o_core_halted), 32'h1);
        count_clk(3, 0, 0, 3);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        check(32'(o_core_halted), 32'h0);
        read_exp(B + 32'h8, ALL);
        count_clk(4, 4, 4, 4);
    endtask

    initial begin
        i_sys_rst     = 1'b1;
        i_req         = '0;
        i_insn_done   = 1'b0;
        i_irq_pending = 1'b0;
        repeat (16) @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_reset_state();
        t_periph();
        t_window();
        t_core();
        t_core_abort();
        t_hw_restart();
        summarize();
    end
endmodule // tb
